// ==== sim/fisp_sequencer_tb.sv ====
`timescale 1ns/1ps
module fisp_sequencer_tb;
	import fisp_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic core_clk, arst_n, reg_wr, reg_rd, flash_ack, large_part;
	logic running_from_loader, rd_pend;
	logic [ADDR_W-1:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, flash_rdata, second_config_word;
	logic flash_req, flash_write, flash_chip_enable, cpu_stall;
	logic power_save_enable, irq;
	logic [3:0] flash_opcode;
	logic [31:0] flash_addr, flash_wdata, a, d, r;
	logic [2:0] sense_window_select;
	logic [31:0] exp_q[$];
	int fail_count, n_tests;

	fisp_sequencer u_fisp_sequencer (
		.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .large_part(large_part),
		.second_config_word(second_config_word),
		.running_from_loader(running_from_loader), .flash_req(flash_req),
		.flash_write(flash_write), .flash_opcode(flash_opcode),
		.flash_chip_enable(flash_chip_enable), .flash_addr(flash_addr),
		.flash_wdata(flash_wdata), .flash_ack(flash_ack),
		.flash_rdata(flash_rdata), .cpu_stall(cpu_stall),
		.sense_window_select(sense_window_select),
		.power_save_enable(power_save_enable), .irq(irq)
	);

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Read data stands only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_pend)
			chk(reg_rdata, exp_q.pop_front());
		rd_pend = reg_rd;
	end

	task summarize;
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge core_clk);
		fail_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// Bus and operation tasks
	// ----------------------------------------------------------------
	task wr(input logic [7:0] ad, input logic [31:0] dt);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_wdata <= dt;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] ad, input logic [31:0] ex);
		exp_q.push_back(ex);
		@(posedge core_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	task do_reset(input logic lp, input logic [31:0] cw);
		arst_n <= 1'b0;
		large_part <= lp;
		second_config_word <= cw;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
	endtask

	task op(input logic [5:0] cmd, input logic [31:0] ad,
		input logic [31:0] dt, input logic [31:0] fr);
		wr(OFS_ADDRESS, ad);
		wr(OFS_DATA, dt);
		wr(OFS_COMMAND, {26'h3FFFFFF, cmd});
		rd(OFS_COMMAND, {26'h0, cmd});
		wr(OFS_TRIGGER, 32'h1);
		#1;
		chk({cpu_stall, flash_req, flash_write, flash_chip_enable,
			flash_opcode}, {2'b11, cmd});
		chk(flash_addr, {ad[31:2], 2'b00});
		chk(flash_wdata, dt);
		rd(OFS_TRIGGER, 32'h1);
		wr(OFS_ADDRESS, ~ad);
		@(posedge core_clk);
		flash_ack <= 1'b1;
		flash_rdata <= fr;
		@(posedge core_clk);
		flash_ack <= 1'b0;
		flash_rdata <= ~fr;
		#1;
		chk({cpu_stall, flash_req}, 0);
		rd(OFS_TRIGGER, 0);
		rd(OFS_ADDRESS, ad);
		rd(OFS_DATA, cmd[5] ? dt : fr);
	endtask

	// Refused start: flag cleared first, so only the refusal sets it
	task bad(input logic [5:0] cmd, input logic [31:0] ad,
		input logic [31:0] ctl);
		wr(OFS_CONTROL, ctl | 32'h40);
		wr(OFS_ADDRESS, ad);
		wr(OFS_COMMAND, {26'h0, cmd});
		wr(OFS_TRIGGER, 32'h1);
		#1;
		chk(flash_req, 0);
		rd(OFS_CONTROL, ctl | 32'h40);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		{arst_n, reg_wr, reg_rd, flash_ack, large_part, rd_pend} = '0;
		running_from_loader = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		second_config_word = '0;
		flash_rdata = 32'hA5A5_5A5A;
		void'($urandom(32'h966CAB1D));
		do_reset(1'b0, 32'h0);
		for (int i = 1; i < 7; i++)
			rd(8'(4 * i), (i == 5) ? DATA_BASE_FIXED : RST_ZERO);
		rd(8'h3C, 0);
		wr(OFS_DATA_BASE, '1);
		rd(OFS_DATA_BASE, DATA_BASE_FIXED);
		wr(OFS_ACCESS_TIME, '1);
		rd(OFS_ACCESS_TIME, 0);
		wr(OFS_UNLOCK, UNLOCK_KEY0);
		wr(OFS_UNLOCK, UNLOCK_KEY1);
		wr(OFS_UNLOCK, UNLOCK_KEY2);
		rd(OFS_UNLOCK, 32'h1);
		wr(OFS_ACCESS_TIME, '1);
		rd(OFS_ACCESS_TIME, 32'hF);
		for (int c = 0; c < 7; c++) begin
			wr(OFS_ACCESS_TIME, {28'h0, 3'(c), 1'(c)});
			@(posedge core_clk);
			chk({sense_window_select, power_save_enable},
				{3'(c), 1'(c)});
		end
		wr(OFS_CONTROL, 32'h1);
		wr(OFS_IRQ_ENABLE, 32'h3);
		// Headroom so that the erase at a + 0x200 stays in range
		a = {16'h0, 14'($urandom), 2'b00};
		d = $urandom;
		r = $urandom;
		op(6'h00, a, d, r);
		chk(irq, 1);
		wr(OFS_IRQ_CLEAR, 32'h3);
		@(posedge core_clk);
		chk(irq, 0);
		op(6'h21, a, $urandom, r);
		op(6'h22, a + 32'h200, d, r);
		wr(OFS_IRQ_CLEAR, 32'h3);
		bad(6'h21, 32'h0040_0000, 32'h1);
		rd(OFS_IRQ_STATUS, 32'h2);
		chk(irq, 1);
		wr(OFS_IRQ_ENABLE, 32'h1);
		@(posedge core_clk);
		chk(irq, 0);
		// Legal run while the fail flag is still up
		op(6'h00, a, d, $urandom);
		rd(OFS_CONTROL, 32'h41);
		bad(6'h23, a, 32'h1);
		bad(6'h21, 32'h0010_0000, 32'h1);
		bad(6'h21, 32'h0020_0000, 32'h1);
		running_from_loader <= 1'b0;
		bad(6'h21, a, 32'h1);
		running_from_loader <= 1'b1;
		bad(6'h00, a, 32'h0);
		wr(OFS_CONTROL, 32'h41);
		rd(OFS_CONTROL, 32'h1);
		// Wrong key relocks; timing bits keep the last loop value
		wr(OFS_UNLOCK, 32'h0);
		rd(OFS_UNLOCK, 32'h0);
		wr(OFS_ACCESS_TIME, 32'h0);
		rd(OFS_ACCESS_TIME, 32'hC);
		d = {12'h0, 11'($urandom), 9'h0};
		// Let the last read answer before reset drops
		repeat (2) @(posedge core_clk);
		do_reset(1'b1, d);
		rd(OFS_DATA_BASE, d);
		wr(OFS_DATA_BASE, 32'h0);
		rd(OFS_DATA_BASE, d);
		repeat (2) @(posedge core_clk);
		summarize();
	end
endmodule

// ==== src/fisp_pkg.sv ====
package fisp_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_ADDRESS = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_COMMAND = 8'h0C;
	localparam logic [7:0] OFS_TRIGGER = 8'h10;
	localparam logic [7:0] OFS_DATA_BASE = 8'h14;
	localparam logic [7:0] OFS_ACCESS_TIME = 8'h18;
	localparam logic [7:0] OFS_UNLOCK = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;

	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int CTL_PROG_EN = 0;
	localparam int CTL_CFG_UEN = 4;
	localparam int CTL_LDR_UEN = 5;
	localparam int CTL_FAIL = 6;
	localparam int CMD_WR = 5;
	localparam int CMD_CE = 4;
	localparam int CMD_W = 6;
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_ERASE = 4'h2;
	localparam int TRG_GO = 0;
	localparam int FAT_PS = 0;
	localparam int FAT_SW_LSB = 1;
	localparam int FAT_SW_W = 3;
	localparam logic [2:0] SW_RESERVED = 3'h7;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_FAIL = 1;
	localparam int IRQ_W = 2;
	localparam int REGION_CFG = 21;
	localparam int REGION_LDR = 20;
	localparam int WORD_LSB = 2;

	// ----------------------------------------------------------------
	// Reset values and keys
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] DATA_BASE_FIXED = 32'h0001_F000;
	localparam logic [7:0] UNLOCK_KEY0 = 8'h59;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h16;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h88;

	typedef enum logic [0:0] {
		FISP_IDLE = 1'b0,
		FISP_BUSY = 1'b1
	} fisp_state_e;

	typedef enum logic [1:0] {
		FISP_KEY_WAIT0 = 2'b00,
		FISP_KEY_WAIT1 = 2'b01,
		FISP_KEY_WAIT2 = 2'b10,
		FISP_KEY_OPEN = 2'b11
	} fisp_key_e;

endpackage

// ==== src/fisp_sequencer.sv ====
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Behaviour
// - Only whole 32-bit word programming exists
// - Read result lands in data register
// - Command: write flag, chip enable, opcode
// - Writing trigger bit 0 starts operation
// - Trigger reads one until hardware finishes
// - Small parts read fixed data base
// - Largest part loads base from config word
// - Three-bit sense window select, 111 reserved
// - Sense window and power save write-protected
// - Timing bit 0 switches power saving
// - Processor stalls while operation runs
module fisp_sequencer #(
	parameter int APP_BYTES = 131072,
	parameter int LDR_BYTES = 4096,
	parameter int CFG_BYTES = 8
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [fisp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic large_part,
	input wire logic [31:0] second_config_word,
	input wire logic running_from_loader,
	output logic flash_req,
	output logic flash_write,
	output logic [3:0] flash_opcode,
	output logic flash_chip_enable,
	output logic [31:0] flash_addr,
	output logic [31:0] flash_wdata,
	input wire logic flash_ack,
	input wire logic [31:0] flash_rdata,
	output logic cpu_stall,
	output logic [2:0] sense_window_select,
	output logic power_save_enable,
	output logic irq
);
	import fisp_pkg::*;

	typedef struct packed {
		fisp_state_e state;
		logic go_bit;
		logic [31:0] operation_address;
		logic [31:0] operation_data_word;
		logic [CMD_W-1:0] operation_command;
		logic programming_enable;
		logic config_update_enable;
		logic loader_update_enable;
		logic operation_fail_flag;
		logic [31:0] data_region_base;
		logic base_loaded;
		logic [2:0] sense_window;
		logic power_save;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_enable;
		logic [31:0] rdata;
	} fisp_seq_s;

	fisp_seq_s st_q;
	fisp_seq_s st_d;

	logic unlocked;
	logic wr_ctl;
	logic wr_adr;
	logic wr_dat;
	logic wr_cmd;
	logic wr_trg;
	logic wr_fat;
	logic wr_unl;
	logic wr_iclr;
	logic wr_ien;
	logic start_req;
	logic is_write;
	logic is_cfg;
	logic is_ldr;
	logic op_known;
	logic in_range;
	logic refuse;
	logic finish;
	logic [IRQ_W-1:0] irq_set;
	logic [31:0] rd_mux;

	// ----------------------------------------------------------------
	// Protection unlock
	// ----------------------------------------------------------------
	fisp_unlock u_unlock (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.key_wr(wr_unl),
		.key_data(reg_wdata[7:0]),
		.unlocked(unlocked)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	assign wr_ctl = reg_wr && (reg_addr == OFS_CONTROL);
	assign wr_adr = reg_wr && (reg_addr == OFS_ADDRESS);
	assign wr_dat = reg_wr && (reg_addr == OFS_DATA);
	assign wr_cmd = reg_wr && (reg_addr == OFS_COMMAND);
	assign wr_trg = reg_wr && (reg_addr == OFS_TRIGGER);
	assign wr_fat = reg_wr && (reg_addr == OFS_ACCESS_TIME);
	assign wr_unl = reg_wr && (reg_addr == OFS_UNLOCK);
	assign wr_iclr = reg_wr && (reg_addr == OFS_IRQ_CLEAR);
	assign wr_ien = reg_wr && (reg_addr == OFS_IRQ_ENABLE);

	// ----------------------------------------------------------------
	// Legality checks on the captured command and address
	// ----------------------------------------------------------------
	assign start_req = wr_trg && reg_wdata[TRG_GO]
		&& (st_q.state == FISP_IDLE);
	assign is_write = st_q.operation_command[CMD_WR];
	assign is_cfg = st_q.operation_address[REGION_CFG];
	assign is_ldr = !is_cfg && st_q.operation_address[REGION_LDR];

	// Only word read, word program and page erase exist
	always_comb begin
		case (st_q.operation_command)
			{1'b0, 1'b0, OP_READ}: op_known = 1'b1;
			{1'b1, 1'b0, OP_PROGRAM}: op_known = 1'b1;
			{1'b1, 1'b0, OP_ERASE}: op_known = 1'b1;
			default: op_known = 1'b0;
		endcase
	end

	// Offset within region, word lanes included in the compare
	always_comb begin
		if (is_cfg) begin
			in_range = st_q.operation_address[REGION_LDR-1:0]
				< 20'(CFG_BYTES);
		end else if (is_ldr) begin
			in_range = st_q.operation_address[REGION_LDR-1:0]
				< 20'(LDR_BYTES);
		end else begin
			in_range = st_q.operation_address[REGION_LDR-1:0]
				< 20'(APP_BYTES);
		end
	end

	// Refusal covers self-writes, locked config and bad targets
	assign refuse = !st_q.programming_enable
		|| !op_known
		|| !in_range
		|| (|st_q.operation_address[31:REGION_CFG+1])
		|| (is_write && !is_cfg && !is_ldr
			&& !running_from_loader)
		|| (is_write && is_ldr && running_from_loader)
		|| (is_write && is_ldr && !st_q.loader_update_enable)
		|| (is_write && is_cfg
			&& !st_q.config_update_enable);

	assign finish = (st_q.state == FISP_BUSY) && flash_ack;
	assign irq_set[IRQ_DONE] = finish;
	assign irq_set[IRQ_FAIL] = start_req && refuse;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.rdata = RST_ZERO;

		// Data base captured once after reset release, never written
		if (!st_q.base_loaded) begin
			st_d.base_loaded = 1'b1;
			st_d.data_region_base = large_part ?
				second_config_word : DATA_BASE_FIXED;
		end

		// Operands frozen while an operation runs
		if (st_q.state == FISP_IDLE) begin
			if (wr_adr) begin
				st_d.operation_address = reg_wdata;
			end
			if (wr_dat) begin
				st_d.operation_data_word = reg_wdata;
			end
			if (wr_cmd) begin
				st_d.operation_command = reg_wdata[CMD_W-1:0];
			end
		end

		if (wr_ctl && unlocked) begin
			st_d.programming_enable = reg_wdata[CTL_PROG_EN];
			st_d.config_update_enable = reg_wdata[CTL_CFG_UEN];
			st_d.loader_update_enable = reg_wdata[CTL_LDR_UEN];
		end
		if (wr_ctl && unlocked && reg_wdata[CTL_FAIL]) begin
			st_d.operation_fail_flag = 1'b0;
		end

		if (wr_fat && unlocked) begin
			st_d.sense_window =
				reg_wdata[FAT_SW_LSB +: FAT_SW_W];
			st_d.power_save = reg_wdata[FAT_PS];
		end

		case (st_q.state)
			FISP_IDLE: begin
				if (start_req && refuse) begin
					st_d.operation_fail_flag = 1'b1;
				end else if (start_req) begin
					st_d.go_bit = 1'b1;
					st_d.state = FISP_BUSY;
				end
			end
			FISP_BUSY: begin
				if (flash_ack) begin
					st_d.go_bit = 1'b0;
					st_d.state = FISP_IDLE;
					if (!is_write) begin
						st_d.operation_data_word = flash_rdata;
					end
				end
			end
			default: begin
				st_d.state = FISP_IDLE;
				st_d.go_bit = 1'b0;
			end
		endcase

		// Set wins over a clear in the same cycle
		if (wr_iclr) begin
			st_d.irq_status = st_q.irq_status & ~reg_wdata[IRQ_W-1:0];
		end
		st_d.irq_status = st_d.irq_status | irq_set;
		if (wr_ien) begin
			st_d.irq_enable = reg_wdata[IRQ_W-1:0];
		end

		if (reg_rd) begin
			st_d.rdata = rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Read mux; reserved bits and unmapped offsets read zero
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = RST_ZERO;
		case (reg_addr)
			OFS_CONTROL: begin
				rd_mux[CTL_PROG_EN] = st_q.programming_enable;
				rd_mux[CTL_CFG_UEN] = st_q.config_update_enable;
				rd_mux[CTL_LDR_UEN] = st_q.loader_update_enable;
				rd_mux[CTL_FAIL] = st_q.operation_fail_flag;
			end
			OFS_ADDRESS: rd_mux = st_q.operation_address;
			OFS_DATA: rd_mux = st_q.operation_data_word;
			OFS_COMMAND: rd_mux[CMD_W-1:0] = st_q.operation_command;
			OFS_TRIGGER: rd_mux[TRG_GO] = st_q.go_bit;
			OFS_DATA_BASE: rd_mux = st_q.data_region_base;
			OFS_ACCESS_TIME: begin
				rd_mux[FAT_SW_LSB +: FAT_SW_W] = st_q.sense_window;
				rd_mux[FAT_PS] = st_q.power_save;
			end
			OFS_UNLOCK: rd_mux[0] = unlocked;
			OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = st_q.irq_status;
			OFS_IRQ_ENABLE: rd_mux[IRQ_W-1:0] = st_q.irq_enable;
			default: rd_mux = RST_ZERO;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '{
				state: FISP_IDLE,
				go_bit: 1'b0,
				operation_address: RST_ZERO,
				operation_data_word: RST_ZERO,
				operation_command: '0,
				programming_enable: 1'b0,
				config_update_enable: 1'b0,
				loader_update_enable: 1'b0,
				operation_fail_flag: 1'b0,
				data_region_base: DATA_BASE_FIXED,
				base_loaded: 1'b0,
				sense_window: '0,
				power_save: 1'b0,
				irq_status: '0,
				irq_enable: '0,
				rdata: RST_ZERO
			};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = st_q.rdata;
	assign flash_req = (st_q.state == FISP_BUSY);
	assign flash_write = st_q.operation_command[CMD_WR];
	assign flash_chip_enable = st_q.operation_command[CMD_CE];
	assign flash_opcode = st_q.operation_command[3:0];
	// Word addressing: lanes forced to zero toward the array
	assign flash_addr = {st_q.operation_address[31:WORD_LSB],
		{WORD_LSB{1'b0}}};
	assign flash_wdata = st_q.operation_data_word;
	// Stall also defers interrupt service; peripherals keep running
	assign cpu_stall = st_q.go_bit;
	assign sense_window_select = st_q.sense_window;
	// Clock-rate limit is software's duty; hardware takes the bit as is
	assign power_save_enable = st_q.power_save;
	assign irq = |(st_q.irq_status & st_q.irq_enable);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_READ_LANDS: assert property (
		@(posedge core_clk) disable iff (!arst_n) finish && !flash_write
		|=> st_q.operation_data_word == $past(flash_rdata))
		else $error("read word not stored in data register");

	AST_GO_HIGH_BUSY: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		start_req && !refuse |=> st_q.go_bit && flash_req)
		else $error("trigger not raised on legal start");

	AST_GO_CLEARS: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		finish |=> !st_q.go_bit && !cpu_stall)
		else $error("trigger not cleared on finish");

	AST_REFUSE: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		start_req && refuse |=> st_q.operation_fail_flag
			&& !st_q.go_bit && st_q.irq_status[IRQ_FAIL])
		else $error("refused start not flagged");

	AST_FAIL_STICKY: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		st_q.operation_fail_flag && !(wr_ctl && unlocked
			&& reg_wdata[CTL_FAIL]) |=> st_q.operation_fail_flag)
		else $error("fail flag dropped without clear");

	AST_PROTECT: assert property (
		@(posedge core_clk) disable iff (!arst_n) wr_fat && !unlocked
		|=> $stable(st_q.sense_window) && $stable(st_q.power_save))
		else $error("protected timing bits written while locked");

	AST_PS_FOLLOWS: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		wr_fat && unlocked |=> power_save_enable
			== $past(reg_wdata[FAT_PS]))
		else $error("power save not updated");

	AST_BUSY_FREEZE: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		flash_req && !flash_ack |=> $stable(flash_addr)
			&& $stable(flash_opcode))
		else $error("operands changed during operation");

	AST_STALL: assert property (
		@(posedge core_clk) disable iff (!arst_n) cpu_stall == flash_req)
		else $error("stall does not match busy");

	AST_BASE_RO: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		st_q.base_loaded |=> $stable(st_q.data_region_base))
		else $error("data base changed after load");

	AST_BASE_SMALL: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		st_q.base_loaded && !$past(large_part) && $past(!st_q.base_loaded)
			|-> st_q.data_region_base == DATA_BASE_FIXED)
		else $error("small part base not fixed value");

	AST_WORD_ADDR: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		flash_addr[WORD_LSB-1:0] == '0)
		else $error("flash address not word aligned");

	AST_RD_ONE_CYCLE: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		!reg_rd |=> reg_rdata == RST_ZERO)
		else $error("read data outside answer cycle");

	AST_NO_PE_NO_GO: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		start_req && !st_q.programming_enable |=> !st_q.go_bit)
		else $error("started without programming enable");

endmodule

// ==== src/fisp_unlock.sv ====
`timescale 1ns/1ps
module fisp_unlock (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic key_wr,
	input wire logic [7:0] key_data,
	output logic unlocked
);
	import fisp_pkg::*;

	typedef struct packed {
		fisp_key_e key;
	} fisp_unlock_s;

	fisp_unlock_s st_q;
	fisp_unlock_s st_d;

	// ----------------------------------------------------------------
	// Key sequence; any wrong byte starts over and relocks
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		if (key_wr) begin
			case (st_q.key)
				FISP_KEY_WAIT0: st_d.key = (key_data == UNLOCK_KEY0) ?
					FISP_KEY_WAIT1 : FISP_KEY_WAIT0;
				FISP_KEY_WAIT1: st_d.key = (key_data == UNLOCK_KEY1) ?
					FISP_KEY_WAIT2 : FISP_KEY_WAIT0;
				FISP_KEY_WAIT2: st_d.key = (key_data == UNLOCK_KEY2) ?
					FISP_KEY_OPEN : FISP_KEY_WAIT0;
				default: st_d.key = (key_data == UNLOCK_KEY0) ?
					FISP_KEY_WAIT1 : FISP_KEY_WAIT0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '{key: FISP_KEY_WAIT0};
		end else begin
			st_q <= st_d;
		end
	end

	assign unlocked = (st_q.key == FISP_KEY_OPEN);

endmodule
